// *** core/hsc_dsp.sv ***
// Function
// - setting splits into filter field bits 5..3 and range field bits 2..0
// - range codes 0..3 select 100, 30, 60, 80 mT full scale
// - filter codes select 500, 125, 250, 62.5 Hz, 1 kHz, else 2 kHz
// - samples pass a low-pass filter; result readable as filtered field
// - order is gain, then offset, then clamp, then converter
// - output code held between low and high clamp limits
// - positive sample means north pole at branded side
// - filtered field readout is 14 bits, read only, before gain
// - filtered field spans -32768 to 32767 for every filter
// - offset is the output at zero field
// - drift coefficient steers temperature compensation of sensitivity
// - clamped result, top 12 of its 13 bits, is the converter input code
// - parameters come from nonvolatile storage loaded by programmer
// - unity gain moves output one supply span per 65536 counts
// - lock key freezes parameters, effective after next power cycle
// - clamp limits span zero to full supply
`timescale 1ns/1ps
module hsc_dsp
   import hsc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // Converter sample stream
   input  wire logic [SAMPLE_W-1:0]  adcSample,
   input  wire logic                 adcValid,
   output logic                      adcReady,
   // Range and drift steering to analog front end
   output logic [RANGE_MSB:0]        adcRangeSel,
   output logic [TC_W-1:0]           tempDriftCoefficient,
   // Output converter stream
   output logic [DAC_W-1:0]          dacCode,
   output logic                      dacValid,
   input  wire logic                 dacReady,
   // Nonvolatile parameter load
   input  wire logic                 nvmLoad,
   input  wire logic [MODE_W-1:0]    nvmRangeFilterSelect,
   input  wire logic [SAMPLE_W-1:0]  nvmSensitivityGain,
   input  wire logic [SAMPLE_W-1:0]  nvmQuiescentOutputOffset,
   input  wire logic [CLAMP_W-1:0]   nvmClampLowLimit,
   input  wire logic [CLAMP_W-1:0]   nvmClampHighLimit,
   input  wire logic [TC_W-1:0]      nvmTempDriftCoefficient,
   input  wire logic [KEY_W-1:0]     nvmParameterLockKey,
   // Register readout
   input  wire logic                 regRdEn,
   input  wire logic [ADDR_W-1:0]    regAddr,
   output logic [SAMPLE_W-1:0]       regRdData,
   output logic                      regRdValid,
   // Lock status
   output logic                      locked
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [MODE_W-1:0]          rangeFilterSelect_q;
   logic [SAMPLE_W-1:0]        sensitivityGain_q;
   logic [SAMPLE_W-1:0]        quiescentOutputOffset_q;
   logic [CLAMP_W-1:0]         clampLowLimit_q;
   logic [CLAMP_W-1:0]         clampHighLimit_q;
   logic [TC_W-1:0]            tempDrift_q;
   logic [KEY_W-1:0]           parameterLockKey_q;
   hsc_lock_e                  lock_q;
   hsc_lock_e                  lock_d;
   logic                       loadOk;

   logic signed [SAMPLE_W-1:0] filtered_q;
   logic signed [SAMPLE_W-1:0] filtered_d;
   logic                       stage1Valid_q;
   logic [DAC_W-1:0]           dacCode_q;
   logic                       dacValid_q;
   logic                       advance;
   logic                       take;

   logic signed [SAMPLE_W-1:0] gainEff;
   logic signed [SAMPLE_W-1:0] offsEff;
   logic [CLAMP_W-1:0]         highEff;
   logic signed [31:0]         product;
   logic signed [WIDE_W-1:0]   scaled;
   logic signed [WIDE_W-1:0]   sumWide;
   logic signed [SAMPLE_W-1:0] sumSat;
   logic signed [SAMPLE_W-1:0] lowS;
   logic signed [SAMPLE_W-1:0] highS;
   logic signed [SAMPLE_W-1:0] clamped;
   logic [CLAMP_W-1:0]         clampCode;

   logic [SAMPLE_W-1:0]        regRdData_q;
   logic                       regRdValid_q;
   logic [SAMPLE_W-1:0]        rdMux;
   logic [SAMPLE_W-1:0]        dfoWord;

   hsc_stream_if #(.WIDTH(SAMPLE_W)) fifoIn ();
   hsc_stream_if #(.WIDTH(SAMPLE_W)) fifoOut ();

   ////////////////////////////////////////////////////////////////////////
   // Sample buffer in front of the filter

   // Samples arrive signed, north pole at branded side positive
   assign fifoIn.data  = adcSample;
   assign fifoIn.valid = adcValid;
   assign adcReady     = fifoIn.ready;

   hsc_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .inPort  (fifoIn),
      .outPort (fifoOut)
   );

   ////////////////////////////////////////////////////////////////////////
   // Lock sequencing

   // Lock decision taken once per power-up, from the key in the first storage load
   always_comb begin
      lock_d = lock_q;
      case (lock_q)
         LK_BOOT: begin
            if (nvmLoad && (nvmParameterLockKey == LOCK_KEY))
               lock_d = LK_FROZEN;
            else if (nvmLoad)
               lock_d = LK_OPEN;
         end
         LK_OPEN:   lock_d = LK_OPEN;
         LK_FROZEN: lock_d = LK_FROZEN;
         default:   lock_d = LK_BOOT;
      endcase
   end

   // Key written while open waits for the next reset to act
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         lock_q <= LK_BOOT;
      else
         lock_q <= lock_d;
   end

   assign loadOk = nvmLoad && (lock_q != LK_FROZEN);
   assign locked = lock_q[1]; // Only the frozen state has bit 1 set

   ////////////////////////////////////////////////////////////////////////
   // Parameter store

   // Lock key image, updated by each load until frozen
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         parameterLockKey_q <= RST_BYTE;
      else if (loadOk)
         parameterLockKey_q <= nvmParameterLockKey;
   end

   // Calibration parameters from storage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rangeFilterSelect_q     <= RST_MODE;
         sensitivityGain_q       <= RST_WORD;
         quiescentOutputOffset_q <= RST_WORD;
         clampLowLimit_q         <= RST_CLAMP;
         clampHighLimit_q        <= RST_CLAMP;
         tempDrift_q             <= RST_BYTE;
      end else if (loadOk) begin
         rangeFilterSelect_q     <= nvmRangeFilterSelect;
         sensitivityGain_q       <= nvmSensitivityGain;
         quiescentOutputOffset_q <= nvmQuiescentOutputOffset;
         clampLowLimit_q         <= nvmClampLowLimit;
         clampHighLimit_q        <= nvmClampHighLimit;
         tempDrift_q             <= nvmTempDriftCoefficient;
      end
   end

   // Range and drift go to the analog side
   assign adcRangeSel          = rangeFilterSelect_q[RANGE_MSB:RANGE_LSB];
   assign tempDriftCoefficient = tempDrift_q;

   ////////////////////////////////////////////////////////////////////////
   // Pipeline control

   // A stage moves only when the converter side has room
   assign advance      = !dacValid_q || dacReady;
   assign take         = fifoOut.valid && advance;
   assign fifoOut.ready = advance;

   ////////////////////////////////////////////////////////////////////////
   // Low-pass filter

   // First-order step: y += (x - y) >>> shift, corner from the field
   always_comb begin
      logic signed [WIDE_W-1:0] diff;
      logic signed [WIDE_W-1:0] step;
      diff = WIDE_W'(signed'(fifoOut.data)) - WIDE_W'(filtered_q);
      step = diff >>> filtShift(rangeFilterSelect_q[FILT_MSB:FILT_LSB]);
      filtered_d = sat16(WIDE_W'(filtered_q) + step);
   end

   // Filter state and first stage valid
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         filtered_q    <= '0;
         stage1Valid_q <= 1'b0;
      end else begin
         if (take)
            filtered_q <= filtered_d;
         if (advance)
            stage1Valid_q <= take;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gain, offset, clamp

   // Undo the stored-bit inversions
   assign gainEff = SAMPLE_W'(sensitivityGain_q ^ GAIN_INV);
   assign offsEff = SAMPLE_W'(quiescentOutputOffset_q ^ OFFS_INV);
   assign highEff = clampHighLimit_q ^ CLAMP_HIGH_LIMIT_INV;

   // Unity gain (8192) gives 8192 output codes per 65536 counts
   assign product = filtered_q * gainEff;
   assign scaled  = WIDE_W'(product >>> PROD_SHIFT);

   // Offset is the zero-field output, on the clamp scale
   assign sumWide = scaled + (WIDE_W'(offsEff) >>> OFFS_SHIFT);
   assign sumSat  = sat16(sumWide);

   // Limits are unsigned, compare on a signed scale
   assign lowS  = SAMPLE_W'({3'h0, clampLowLimit_q});
   assign highS = SAMPLE_W'({3'h0, highEff});

   // Band limit, high limit taken last
   always_comb begin
      clamped = sumSat;
      if (sumSat < lowS)
         clamped = lowS;
      if (clamped > highS)
         clamped = highS;
   end

   assign clampCode = clamped[CLAMP_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Converter output register

   // Code holds until the converter takes it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dacCode_q  <= '0;
         dacValid_q <= 1'b0;
      end else if (advance) begin
         dacValid_q <= stage1Valid_q;
         if (stage1Valid_q)
            dacCode_q <= clampCode[CLAMP_W-1:DAC_SHIFT];
      end
   end

   assign dacCode  = dacCode_q;
   assign dacValid = dacValid_q;

   ////////////////////////////////////////////////////////////////////////
   // Register readout

   // Only the top 14 bits of the filtered value are meaningful
   assign dfoWord = {filtered_q[SAMPLE_W-1:DFO_LSB], {DFO_LSB{1'b0}}};

   // Address decode, unmapped reads return zero
   always_comb begin
      case (regAddr)
         ADDR_LOCK: rdMux = {8'h00, parameterLockKey_q};
         ADDR_CLAMP_LOW_LIMIT: rdMux = {3'h0, clampLowLimit_q};
         ADDR_CLAMP_HIGH_LIMIT: rdMux = {3'h0, clampHighLimit_q};
         ADDR_OFFS: rdMux = quiescentOutputOffset_q;
         ADDR_GAIN: rdMux = sensitivityGain_q;
         ADDR_MODE: rdMux = {10'h000, rangeFilterSelect_q};
         ADDR_TC:   rdMux = {8'h00, tempDrift_q};
         ADDR_DFO:  rdMux = dfoWord;
         default:   rdMux = '0;
      endcase
   end

   // Read answer one cycle after the request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData_q  <= '0;
         regRdValid_q <= 1'b0;
      end else begin
         regRdValid_q <= regRdEn;
         if (regRdEn)
            regRdData_q <= rdMux;
      end
   end

   assign regRdData  = regRdData_q;
   assign regRdValid = regRdValid_q;

endmodule

// *** core/hsc_pkg.sv ***
package hsc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int SAMPLE_W   = 16;
   localparam int DFO_W      = 14;
   localparam int CLAMP_W    = 13;
   localparam int DAC_W      = 12;
   localparam int MODE_W     = 6;
   localparam int TC_W       = 8;
   localparam int KEY_W      = 8;
   localparam int ADDR_W     = 5;
   localparam int FIFO_DEPTH = 16;
   localparam int WIDE_W     = 20;

   ////////////////////////////////////////////////////////////////////////
   // Setting field layout: filter high, range low
   localparam int FILT_MSB  = 5;
   localparam int FILT_LSB  = 3;
   localparam int RANGE_MSB = 2;
   localparam int RANGE_LSB = 0;
   localparam int DFO_LSB   = SAMPLE_W - DFO_W;

   ////////////////////////////////////////////////////////////////////////
   // Read addresses
   localparam logic [4:0] ADDR_LOCK  = 5'h01;
   localparam logic [4:0] ADDR_CLAMP_LOW_LIMIT  = 5'h02;
   localparam logic [4:0] ADDR_CLAMP_HIGH_LIMIT  = 5'h04;
   localparam logic [4:0] ADDR_OFFS  = 5'h06;
   localparam logic [4:0] ADDR_GAIN  = 5'h08;
   localparam logic [4:0] ADDR_MODE  = 5'h0C;
   localparam logic [4:0] ADDR_TC    = 5'h0E;
   localparam logic [4:0] ADDR_DFO   = 5'h18;

   ////////////////////////////////////////////////////////////////////////
   // Stored-bit inversions, lock key, reset values
   localparam logic [12:0] CLAMP_HIGH_LIMIT_INV  = 13'h1FFF;
   localparam logic [15:0] GAIN_INV  = 16'h2000;
   localparam logic [15:0] OFFS_INV  = 16'h1000;
   localparam logic [7:0]  LOCK_KEY  = 8'hB6;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [12:0] RST_CLAMP = 13'h0000;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [5:0]  RST_MODE  = 6'h00;

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic scaling: unity gain is 8192, product scaled by 2^16
   localparam int PROD_SHIFT = 16;
   localparam int OFFS_SHIFT = 1;
   localparam int DAC_SHIFT  = 1;

   // Filter corner to first-order shift (larger shift, lower corner)
   localparam logic [2:0] FSH_500 = 3'h3;
   localparam logic [2:0] FSH_125 = 3'h5;
   localparam logic [2:0] FSH_250 = 3'h4;
   localparam logic [2:0] FSH_62  = 3'h6;
   localparam logic [2:0] FSH_1K  = 3'h2;
   localparam logic [2:0] FSH_2K  = 3'h1;

   typedef enum logic [1:0] {
      LK_BOOT   = 2'b00,
      LK_OPEN   = 2'b01,
      LK_FROZEN = 2'b11
   } hsc_lock_e;

   // Filter code to shift; codes 5..7 share the widest corner
   function automatic logic [2:0] filtShift(input logic [2:0] code);
      case (code)
         3'h0:    filtShift = FSH_500;
         3'h1:    filtShift = FSH_125;
         3'h2:    filtShift = FSH_250;
         3'h3:    filtShift = FSH_62;
         3'h4:    filtShift = FSH_1K;
         default: filtShift = FSH_2K;
      endcase
   endfunction

   // Saturate a wide signed value to the sample width
   function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
      if (v > 20'sh07FFF)
         sat16 = 16'sh7FFF;
      else if (v < -20'sh08000)
         sat16 = -16'sh8000;
      else
         sat16 = v[15:0];
   endfunction

endpackage

// *** core/hsc_stream_if.sv ***
`timescale 1ns/1ps
interface hsc_stream_if #(parameter int WIDTH = 16);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// *** core/hsc_fifo.sv ***
`timescale 1ns/1ps
module hsc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Filling side
   hsc_stream_if.snk inPort,
   // Draining side
   hsc_stream_if.src outPort
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] FULLCNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_q;
   logic [PW-1:0]    rdPtr_q;
   logic [CW-1:0]    cnt_q;
   logic [CW-1:0]    cnt_d;
   logic             full_q;
   logic             empty_q;
   logic             push;
   logic             pop;

   assign push          = inPort.valid && !full_q;
   assign pop           = !empty_q && outPort.ready;
   assign inPort.ready  = !full_q;
   assign outPort.valid = !empty_q;
   assign outPort.data  = mem[rdPtr_q];

   // Occupancy after this cycle
   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + CW'(1);
      else if (pop && !push)
         cnt_d = cnt_q - CW'(1);
   end

   // Storage write
   always_ff @(posedge ref_clk) begin
      if (push)
         mem[wrPtr_q] <= inPort.data;
   end

   // Pointers and flags
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q   <= '0;
         full_q  <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         if (push)
            wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + PW'(1);
         if (pop)
            rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + PW'(1);
         cnt_q   <= cnt_d;
         full_q  <= (cnt_d == FULLCNT);
         empty_q <= (cnt_d == '0);
      end
   end
endmodule

// *** verification/hsc_dsp_sva.sv ***
`timescale 1ns/1ps
module hsc_dsp_chk
   import hsc_pkg::*;
(
   // Clock and reset
   input wire logic                ref_clk,
   input wire logic                rst_n,
   // Streams
   input wire logic                adcValid,
   input wire logic                adcReady,
   input wire logic [DAC_W-1:0]    dacCode,
   input wire logic                dacValid,
   input wire logic                dacReady,
   // Settings
   input wire logic [RANGE_MSB:0]  adcRangeSel,
   input wire logic [TC_W-1:0]     tempDriftCoefficient,
   input wire logic                nvmLoad,
   input wire logic [MODE_W-1:0]   nvmRangeFilterSelect,
   input wire logic [CLAMP_W-1:0]  nvmClampLowLimit,
   input wire logic [CLAMP_W-1:0]  nvmClampHighLimit,
   input wire logic [TC_W-1:0]     nvmTempDriftCoefficient,
   // Readout and lock
   input wire logic                regRdEn,
   input wire logic [ADDR_W-1:0]   regAddr,
   input wire logic [SAMPLE_W-1:0] regRdData,
   input wire logic                regRdValid,
   input wire logic                locked
);
   logic [MODE_W-1:0]  mode_q;
   logic [CLAMP_W-1:0] low_q;
   logic [CLAMP_W-1:0] high_q;
   logic [CLAMP_W-1:0] highEff;
   logic               unmapped;

   ////////////////////////////////////////////////////////////////////////
   // Shadow of accepted settings
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= RST_MODE;
         low_q <= RST_CLAMP;
         high_q <= RST_CLAMP;
      end else if (nvmLoad && !locked) begin
         mode_q <= nvmRangeFilterSelect;
         low_q <= nvmClampLowLimit;
         high_q <= nvmClampHighLimit;
      end
   end

   // Effective high limit and address decode
   assign highEff = high_q ^ CLAMP_HIGH_LIMIT_INV;
   assign unmapped = !(regAddr inside {ADDR_LOCK, ADDR_CLAMP_LOW_LIMIT, ADDR_CLAMP_HIGH_LIMIT, ADDR_OFFS, ADDR_GAIN, ADDR_MODE, ADDR_TC,
                                       ADDR_DFO});

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_rdReq; regRdEn; endsequence
   sequence s_rdAns; regRdValid; endsequence
   sequence s_loadQuiet; nvmLoad && !locked ##1 !nvmLoad; endsequence

   property p_rdAnswer; s_rdReq |=> s_rdAns; endproperty
   property p_rdQuiet; !regRdEn |=> !regRdValid; endproperty
   property p_rdUnmapped; s_rdReq and unmapped |=> regRdData == 16'h0000; endproperty
   property p_rdSetting; s_rdReq and regAddr == ADDR_MODE |=> regRdData == {10'h000, mode_q}; endproperty
   property p_rangeOut; s_loadQuiet |=> adcRangeSel == mode_q[RANGE_MSB:0]; endproperty
   property p_driftOut; s_loadQuiet |=> tempDriftCoefficient == $past(nvmTempDriftCoefficient, 2); endproperty
   property p_dacHold; dacValid && !dacReady |=> dacValid && $stable(dacCode); endproperty
   property p_clampBand;
      dacValid |-> dacCode <= highEff[12:1] && (low_q > highEff || dacCode >= low_q[12:1]);
   endproperty
   property p_fullCause; $fell(adcReady) |-> $past(adcValid); endproperty
   property p_release; $rose(rst_n) |-> adcReady && !dacValid && !locked && !regRdValid; endproperty

   a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
   a_rdQuiet: assert property (p_rdQuiet) else $error("read answer without request");
   a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
   a_rdSetting: assert property (p_rdSetting) else $error("setting readback wrong");
   a_rangeOut: assert property (p_rangeOut) else $error("range select wrong");
   a_driftOut: assert property (p_driftOut) else $error("drift coefficient wrong");
   a_dacHold: assert property (p_dacHold) else $error("converter code moved while stalled");
   a_clampBand: assert property (p_clampBand) else $error("code outside clamp band");
   a_fullCause: assert property (p_fullCause) else $error("full without push");
   a_release: assert property (p_release) else $error("outputs wrong after reset");
endmodule

bind hsc_dsp hsc_dsp_chk u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .adcValid(adcValid), .adcReady(adcReady), .dacCode(dacCode),
   .dacValid(dacValid), .dacReady(dacReady), .adcRangeSel(adcRangeSel), .tempDriftCoefficient(tempDriftCoefficient),
   .nvmLoad(nvmLoad), .nvmRangeFilterSelect(nvmRangeFilterSelect), .nvmClampLowLimit(nvmClampLowLimit),
   .nvmClampHighLimit(nvmClampHighLimit), .nvmTempDriftCoefficient(nvmTempDriftCoefficient), .regRdEn(regRdEn),
   .regAddr(regAddr), .regRdData(regRdData), .regRdValid(regRdValid), .locked(locked)
);

// *** verification/hsc_front_model.sv ***
`timescale 1ns/1ps
module hsc_front_model
   import hsc_pkg::*;
(
   // Clock
   input wire logic                ref_clk,
   // Sample stream
   output logic [SAMPLE_W-1:0]     adcSample,
   output logic                    adcValid,
   input wire logic                adcReady,
   // Converter stream
   input wire logic [DAC_W-1:0]    dacCode,
   input wire logic                dacValid,
   output logic                    dacReady,
   // Bench steering
   input wire logic                stall
);
   int codes[$];

   initial begin
      adcSample = 16'h0000;
      adcValid = 1'b0;
      dacReady = 1'b0;
   end

   // Converter takes codes with random pauses, none while stalled
   always @(posedge ref_clk) begin
      if (dacValid && dacReady)
         codes.push_back(int'(dacCode));
      dacReady <= !stall && ($urandom_range(3) != 0);
   end

   // Offer one signed sample and hold it until taken
   task automatic send(input logic [SAMPLE_W-1:0] s);
      adcSample <= s;
      adcValid <= 1'b1;
      do @(posedge ref_clk); while (adcReady !== 1'b1);
   endtask

   // Release the line; data scrambled so nothing stale looks valid
   task automatic idle();
      adcValid <= 1'b0;
      adcSample <= ~adcSample;
   endtask
endmodule

// *** verification/tb_hsc_dsp.sv ***
`timescale 1ns/1ps
module tb_hsc_dsp
   import hsc_pkg::*;
;
   logic                ref_clk;
   logic                rst_n;
   logic [SAMPLE_W-1:0] adcSample;
   logic                adcValid;
   logic                adcReady;
   logic [RANGE_MSB:0]  adcRangeSel;
   logic [TC_W-1:0]     tempDriftCoefficient;
   logic [DAC_W-1:0]    dacCode;
   logic                dacValid;
   logic                dacReady;
   logic                nvmLoad;
   logic [MODE_W-1:0]   modeRaw;
   logic [SAMPLE_W-1:0] gRaw;
   logic [SAMPLE_W-1:0] oRaw;
   logic [CLAMP_W-1:0]  loRaw;
   logic [CLAMP_W-1:0]  hiRaw;
   logic [TC_W-1:0]     tcRaw;
   logic [KEY_W-1:0]    keyRaw;
   logic                regRdEn;
   logic [ADDR_W-1:0]   regAddr;
   logic [SAMPLE_W-1:0] regRdData;
   logic                regRdValid;
   logic                locked;
   logic                stall;
   int                  errors;
   int                  testsRun;
   int                  cycles;
   int                  yM;
   int                  expQ[$];
   int                  shiftTab[8] = '{3, 5, 4, 6, 2, 1, 1, 1};

   hsc_dsp uut (.ref_clk(ref_clk), .rst_n(rst_n), .adcSample(adcSample), .adcValid(adcValid), .adcReady(adcReady),
      .adcRangeSel(adcRangeSel), .tempDriftCoefficient(tempDriftCoefficient), .dacCode(dacCode), .dacValid(dacValid),
      .dacReady(dacReady), .nvmLoad(nvmLoad), .nvmRangeFilterSelect(modeRaw), .nvmSensitivityGain(gRaw),
      .nvmQuiescentOutputOffset(oRaw), .nvmClampLowLimit(loRaw), .nvmClampHighLimit(hiRaw),
      .nvmTempDriftCoefficient(tcRaw), .nvmParameterLockKey(keyRaw), .regRdEn(regRdEn), .regAddr(regAddr),
      .regRdData(regRdData), .regRdValid(regRdValid), .locked(locked));

   hsc_front_model pm (.ref_clk(ref_clk), .adcSample(adcSample), .adcValid(adcValid), .adcReady(adcReady),
      .dacCode(dacCode), .dacValid(dacValid), .dacReady(dacReady), .stall(stall));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         endOfTest();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic endOfTest();
      if (errors == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Expected converter code: gain, offset, saturate, clamp low then high
   function automatic int outCode(input int y);
      int p;
      p = ((y * int'(signed'(gRaw ^ GAIN_INV))) >>> 16) + (int'(signed'(oRaw ^ OFFS_INV)) >>> 1);
      if (p > 32767) p = 32767;
      if (p < -32768) p = -32768;
      if (p < int'(loRaw)) p = int'(loRaw);
      if (p > int'(hiRaw ^ CLAMP_HIGH_LIMIT_INV)) p = int'(hiRaw ^ CLAMP_HIGH_LIMIT_INV);
      return p >>> 1;
   endfunction

   // Read one address and compare the answer a cycle later
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      @(negedge ref_clk);
      check(regRdValid, 1'b1);
      check(regRdData, exp);
      @(posedge ref_clk);
   endtask

   task automatic readAll();
      rd(ADDR_LOCK, {8'h00, keyRaw});
      rd(ADDR_CLAMP_LOW_LIMIT, {3'h0, loRaw});
      rd(ADDR_CLAMP_HIGH_LIMIT, {3'h0, hiRaw});
      rd(ADDR_OFFS, oRaw);
      rd(ADDR_GAIN, gRaw);
      rd(ADDR_MODE, {10'h000, modeRaw});
      rd(ADDR_TC, {8'h00, tcRaw});
      rd(ADDR_DFO, 16'(yM) & 16'hFFFC);
      rd(5'h1F, 16'h0000);
   endtask

   // Load a random parameter set with the given setting
   task automatic load(input logic [MODE_W-1:0] m, input logic [KEY_W-1:0] k);
      modeRaw <= m;
      gRaw <= 16'($urandom);
      oRaw <= 16'($urandom);
      loRaw <= 13'($urandom_range(2047));
      hiRaw <= 13'($urandom_range(2047));
      tcRaw <= 8'($urandom);
      keyRaw <= k;
      nvmLoad <= 1'b1;
      @(posedge ref_clk);
      nvmLoad <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check({13'h0000, adcRangeSel}, {13'h0000, modeRaw[RANGE_MSB:0]});
      check({8'h00, tempDriftCoefficient}, {8'h00, tcRaw});
   endtask

   // Stream samples, model the filter and compare every code in order
   task automatic burst(input int n);
      logic [15:0] s;
      int          w;
      for (int i = 0; i < n; i++) begin
         s = 16'($urandom);
         yM = yM + ((int'(signed'(s)) - yM) >>> shiftTab[modeRaw[FILT_MSB:FILT_LSB]]);
         if (yM > 32767) yM = 32767;
         if (yM < -32768) yM = -32768;
         expQ.push_back(outCode(yM));
         pm.send(s);
      end
      pm.idle();
      w = 0;
      while (pm.codes.size() < expQ.size() && w < 400) begin
         @(posedge ref_clk);
         w++;
      end
      check(16'(pm.codes.size()), 16'(expQ.size()));
      while (expQ.size() > 0 && pm.codes.size() > 0)
         check(16'(pm.codes.pop_front()), 16'(expQ.pop_front()));
      expQ.delete();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'hf99b));
      {rst_n, nvmLoad, regRdEn, stall, regAddr} = '0;
      {modeRaw, gRaw, oRaw, loRaw, hiRaw, tcRaw, keyRaw} = '0;
      yM = 0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      readAll();
      check(locked, 1'b0);
      for (int f = 0; f < 8; f++) begin
         load({3'(f), 3'(f % 4)}, (f == 7) ? LOCK_KEY : 8'($urandom_range(8'hB5)));
         burst(12);
      end
      check(locked, 1'b0);
      readAll();
      fork
         burst(24);
         begin
            stall <= 1'b1;
            repeat (40) @(posedge ref_clk);
            check(adcReady, 1'b0);
            stall <= 1'b0;
         end
      join
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      {modeRaw, gRaw, oRaw, loRaw, hiRaw, tcRaw, keyRaw} <= '0;
      yM = 0;
      @(posedge ref_clk);
      readAll();
      load(6'h2B, LOCK_KEY);
      check(locked, 1'b1);
      {nvmLoad, tcRaw} <= {1'b1, ~tcRaw};
      @(posedge ref_clk);
      {nvmLoad, tcRaw} <= {1'b0, ~tcRaw};
      @(posedge ref_clk);
      readAll();
      endOfTest();
   end
endmodule
